/* hdl/aord_mag_cmp.sv */
// Sample magnitude and two-threshold compare
`timescale 1ns/1ps
module aord_mag_cmp (
   // Sample in
   input  wire  logic [aord_pkg::SMP_W-1:0] sample,
   // Thresholds
   input  wire  logic [aord_pkg::TOP_W-1:0] high_threshold,
   input  wire  logic [aord_pkg::TOP_W-1:0] low_threshold,
   // Results
   output logic       [aord_pkg::MAG_W-1:0] mag,
   output aord_pkg::aord_flags_type         hit
);
   import aord_pkg::*;

   logic [SMP_W-1:0] neg;
   logic [TOP_W-1:0] top;

   always_comb begin
      neg = SMP_W'(~sample + 12'h001);
      if (!sample[SMP_W-1]) begin
         mag = sample[MAG_W-1:0];
      end else if (sample == 12'h800) begin
         mag = 11'h7FF; // Most negative code saturates
      end else begin
         mag = neg[MAG_W-1:0];
      end
      top = mag[MAG_W-1:MAG_W-TOP_W];
      hit.high = (top >= high_threshold);
      hit.low  = (top >= low_threshold);
   end

endmodule // aord_mag_cmp

/* hdl/aord_pkg.sv */
// Shared constants and carrier types for the over-range detector
package aord_pkg;

   // Data widths
   localparam int SMP_W = 12;
   localparam int MAG_W = 11;
   localparam int TOP_W = 8;
   localparam int DEC_W = 16;
   localparam int HOLD_W = 3;
   localparam int LEN_W = 11;
   localparam int WIN_W = 9;
   localparam int IDX_W = 10;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_HIGH_THR = 10'h211;
   localparam logic [IDX_W-1:0] IDX_LOW_THR  = 10'h212;
   localparam logic [IDX_W-1:0] IDX_OVR_CFG  = 10'h213;
   localparam logic [IDX_W-1:0] IDX_MODE     = 10'h214;
   localparam logic [IDX_W-1:0] IDX_STATUS   = 10'h215;

   // Reset values
   localparam logic [7:0]  RST_OVR_CFG  = 8'h07;
   localparam logic [7:0]  RST_HIGH_THR = 8'hE4;
   localparam logic [7:0]  RST_LOW_THR  = 8'h40;
   localparam logic [12:0] RST_MODE     = 13'h0000;

   // Field positions
   localparam int CFG_HOLD_LSB    = 0;
   localparam int MODE_SINGLE_BIT = 0;
   localparam int MODE_BGCAL_BIT  = 1;
   localparam int MODE_FMT_LSB    = 8;
   localparam int FMT_W           = 5;

   // Link format codes that carry embedded status, and the complex code that does not
   localparam logic [FMT_W-1:0] FMT_REAL_DEC   = 5'h09;
   localparam logic [FMT_W-1:0] FMT_CPLX_FIRST = 5'h0A;
   localparam logic [FMT_W-1:0] FMT_CPLX_LAST  = 5'h10;
   localparam logic [FMT_W-1:0] FMT_CPLX_SKIP  = 5'h0C;

   // Timing: shortest status pulse in device clock cycles, shortest monitoring windows in samples
   localparam logic [LEN_W-1:0] HOLD_BASE_CYC = 11'h008;
   localparam logic [WIN_W-1:0] WIN_BASE_CPLX = 9'h001;
   localparam logic [WIN_W-1:0] WIN_BASE_REAL = 9'h002;

   typedef struct packed {
      logic high;
      logic low;
   } aord_flags_type;

   typedef struct packed {
      logic [SMP_W-1:0] lane1;
      logic [SMP_W-1:0] lane0;
   } aord_lanes_type;

   typedef struct packed {
      logic [DEC_W-1:0] b;
      logic [DEC_W-1:0] a;
   } aord_dec_type;

   typedef enum logic [1:0] {
      DP_NONE  = 2'b00,
      DP_WRITE = 2'b01,
      DP_READ  = 2'b10
   } aord_dphase_type;

endpackage

/* hdl/aord_stretch.sv */
// Status pulse stretcher restarted by each over-range event
`timescale 1ns/1ps
module aord_stretch (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         srst,
   // Event and length
   input  wire logic                         hit,
   input  wire logic [aord_pkg::HOLD_W-1:0]  hold_sel,
   // Stretched flag
   output logic                              flag
);
   import aord_pkg::*;

   logic [LEN_W-1:0] cnt_ff;
   logic             flag_ff;
   logic [LEN_W-1:0] len;

   assign len  = LEN_W'(HOLD_BASE_CYC << hold_sel);
   assign flag = flag_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_ff  <= 11'h000;
         flag_ff <= 1'b0;
      end else if (hit) begin
         cnt_ff  <= LEN_W'(len - 11'h001); // Restart from latest event
         flag_ff <= 1'b1;
      end else if (cnt_ff != 11'h000) begin
         cnt_ff  <= LEN_W'(cnt_ff - 11'h001);
      end else begin
         flag_ff <= 1'b0;
      end
   end

   a_flag_set: assert property (@(posedge clk) disable iff (srst)
      hit |=> flag)
      else $error("flag not raised after event");

   a_hold_load: assert property (@(posedge clk) disable iff (srst)
      hit |=> (cnt_ff == LEN_W'($past(len) - 11'h001)))
      else $error("hold count not loaded");

   a_hold_drop: assert property (@(posedge clk) disable iff (srst)
      $fell(flag) |-> ($past(cnt_ff) == 11'h000 && !$past(hit)))
      else $error("flag dropped early");

endmodule // aord_stretch

/* hdl/aord_top.sv */
// Over-range detector with status pins, embedded bits and AHB-Lite registers
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
module aord_top (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    srst,
   // AHB-Lite slave
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic                    hready,
   input  wire logic [31:0]             hwdata,
   output logic      [31:0]             hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   // Converter samples and calibration engine
   input  wire logic                    smp_valid,
   input  wire aord_pkg::aord_lanes_type smp_in,
   input  wire logic                    cal_busy,
   output logic                         smp_out_valid,
   output aord_pkg::aord_lanes_type     smp_out,
   // Over-range status pins
   output logic                         chan_a_high_flag,
   output logic                         chan_a_low_flag,
   output logic                         chan_b_high_flag,
   output logic                         chan_b_low_flag,
   // Decimated data stream
   input  wire logic                    dec_valid,
   input  wire logic                    dec_phase,
   input  wire aord_pkg::aord_dec_type  dec_in,
   output logic                         dec_out_valid,
   output aord_pkg::aord_dec_type       dec_out
);
   import aord_pkg::*;

   // Register file
   logic [7:0]        high_thr_ff;
   logic [7:0]        low_thr_ff;
   logic [7:0]        ovr_cfg_ff;
   logic [12:0]       mode_ff;
   aord_dphase_type   dp_state_ff;
   logic [IDX_W-1:0]  dp_idx_ff;
   logic [31:0]       hrdata_ff;
   logic [31:0]       nxt_hrdata;
   logic              addr_ok;
   logic              ap_take;
   logic              wr_en;

   // Datapath
   logic [HOLD_W-1:0] hold_length_select;
   logic [FMT_W-1:0]  link_format_select;
   logic              single_mode;
   logic              bg_cal;
   logic              take;
   logic              embed_real;
   logic              embed_cplx;
   logic              embed_on;
   logic [WIN_W-1:0]  period;
   logic [WIN_W-1:0]  win_cnt_ff;
   logic              win_end;
   logic [SMP_W-1:0]  lane_smp [2];
   logic [MAG_W-1:0]  lane_mag [2];
   aord_flags_type    lane_hit [2];
   aord_flags_type    pin_flag [2];
   aord_flags_type    emb_ff [2];
   logic              smp_out_valid_ff;
   aord_lanes_type    smp_out_ff;
   logic              dec_out_valid_ff;
   aord_dec_type      dec_out_ff;
   logic [DEC_W-1:0]  dec_word [2];
   logic [DEC_W-1:0]  dec_mark [2];

   assign hold_length_select = ovr_cfg_ff[CFG_HOLD_LSB +: HOLD_W];
   assign link_format_select = mode_ff[MODE_FMT_LSB +: FMT_W];
   assign single_mode        = mode_ff[MODE_SINGLE_BIT];
   assign bg_cal             = mode_ff[MODE_BGCAL_BIT];

   // Bus slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;
   assign addr_ok   = (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'b00);
   assign ap_take   = hsel && htrans[1] && hready;
   assign wr_en     = (dp_state_ff == DP_WRITE);

   always_ff @(posedge clk) begin
      if (srst) begin
         dp_state_ff <= DP_NONE;
         dp_idx_ff   <= 10'h000;
      end else if (hready) begin
         dp_idx_ff <= addr_ok ? haddr[11:2] : 10'h000;
         case ({ap_take, hwrite})
            2'b11:   dp_state_ff <= DP_WRITE;
            2'b10:   dp_state_ff <= DP_READ;
            default: dp_state_ff <= DP_NONE;
         endcase
      end
   end

   // Read value formed in the address phase so hrdata comes from a flop
   always_comb begin
      nxt_hrdata = 32'h00000000;
      if (addr_ok) begin
         case (haddr[11:2])
            IDX_HIGH_THR: nxt_hrdata = {24'h000000, high_thr_ff};
            IDX_LOW_THR:  nxt_hrdata = {24'h000000, low_thr_ff};
            IDX_OVR_CFG:  nxt_hrdata = {24'h000000, ovr_cfg_ff};
            IDX_MODE:     nxt_hrdata = {19'h00000, mode_ff};
            IDX_STATUS:   nxt_hrdata = {27'h0000000, cal_busy,
                                        pin_flag[1].low, pin_flag[1].high,
                                        pin_flag[0].low, pin_flag[0].high};
            default:      nxt_hrdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         hrdata_ff <= 32'h00000000;
      end else if (ap_take && !hwrite) begin
         hrdata_ff <= nxt_hrdata;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         high_thr_ff <= RST_HIGH_THR;
         low_thr_ff  <= RST_LOW_THR;
      end else if (wr_en && dp_idx_ff == IDX_HIGH_THR) begin
         high_thr_ff <= hwdata[7:0];
      end else if (wr_en && dp_idx_ff == IDX_LOW_THR) begin
         low_thr_ff <= hwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ovr_cfg_ff <= RST_OVR_CFG;
      end else if (wr_en && dp_idx_ff == IDX_OVR_CFG) begin
         ovr_cfg_ff <= {5'h00, hwdata[CFG_HOLD_LSB +: HOLD_W]};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mode_ff <= RST_MODE;
      end else if (wr_en && dp_idx_ff == IDX_MODE) begin
         mode_ff <= {hwdata[12:8], 6'h00, hwdata[1:0]};
      end
   end

   // Foreground calibration stops sampling; background keeps it running
   assign take = smp_valid && !(cal_busy && !bg_cal);

   // Lane 0 feeds the A pins, lane 1 the B pins. In dual mode the lanes are
   // channels A and B on the rising edge; in single mode they are the rising
   // and falling edge samples of one input, so each threshold spans both pins.
   assign lane_smp[0] = smp_in.lane0;
   assign lane_smp[1] = smp_in.lane1;

   always_ff @(posedge clk) begin
      if (srst) begin
         smp_out_valid_ff <= 1'b0;
         smp_out_ff       <= '0;
      end else begin
         smp_out_valid_ff <= take;
         if (take) begin
            smp_out_ff <= smp_in; // Twos complement codes pass unchanged
         end
      end
   end

   assign smp_out_valid = smp_out_valid_ff;
   assign smp_out       = smp_out_ff;

   // Embedding only in decimating formats
   assign embed_real = (link_format_select == FMT_REAL_DEC);
   assign embed_cplx = (link_format_select >= FMT_CPLX_FIRST) &&
                       (link_format_select <= FMT_CPLX_LAST) &&
                       (link_format_select != FMT_CPLX_SKIP);
   assign embed_on   = embed_real || embed_cplx;

   assign period  = embed_real ? WIN_W'(WIN_BASE_REAL << hold_length_select)
                               : WIN_W'(WIN_BASE_CPLX << hold_length_select);
   // Greater-or-equal so a shortened period mid-window still wraps
   assign win_end = take && (win_cnt_ff >= WIN_W'(period - 9'h001));

   always_ff @(posedge clk) begin
      if (srst) begin
         win_cnt_ff <= 9'h000;
      end else if (win_end) begin
         win_cnt_ff <= 9'h000;
      end else if (take) begin
         win_cnt_ff <= WIN_W'(win_cnt_ff + 9'h001);
      end
   end

   genvar l;
   generate
      for (l = 0; l < 2; l++) begin : g_lane
         aord_flags_type acc_ff;

         // Same threshold pair on both lanes
         aord_mag_cmp u_mag (
            .sample         (lane_smp[l]),
            .high_threshold (high_thr_ff),
            .low_threshold  (low_thr_ff),
            .mag            (lane_mag[l]),
            .hit            (lane_hit[l])
         );

         aord_stretch u_hold_high (
            .clk      (clk),
            .srst     (srst),
            .hit      (take && lane_hit[l].high),
            .hold_sel (hold_length_select),
            .flag     (pin_flag[l].high)
         );

         aord_stretch u_hold_low (
            .clk      (clk),
            .srst     (srst),
            .hit      (take && lane_hit[l].low),
            .hold_sel (hold_length_select),
            .flag     (pin_flag[l].low)
         );

         // Window accumulator; the sample that closes a window still counts
         always_ff @(posedge clk) begin
            if (srst) begin
               acc_ff    <= '0;
               emb_ff[l] <= '0;
            end else if (win_end) begin
               acc_ff    <= '0;
               emb_ff[l] <= acc_ff | lane_hit[l];
            end else if (take) begin
               acc_ff <= acc_ff | lane_hit[l];
            end
         end

         // I or even samples carry the high flag, Q or odd the low flag
         assign dec_word[l] = l == 0 ? dec_in.a : dec_in.b;
         assign dec_mark[l] = {dec_word[l][DEC_W-1:1],
                               dec_phase ? emb_ff[l].low : emb_ff[l].high};
      end
   endgenerate

   assign chan_a_high_flag = pin_flag[0].high;
   assign chan_a_low_flag  = pin_flag[0].low;
   assign chan_b_high_flag = pin_flag[1].high;
   assign chan_b_low_flag  = pin_flag[1].low;

   always_ff @(posedge clk) begin
      if (srst) begin
         dec_out_valid_ff <= 1'b0;
         dec_out_ff       <= '0;
      end else begin
         dec_out_valid_ff <= dec_valid;
         if (dec_valid) begin
            dec_out_ff.a <= embed_on ? dec_mark[0] : dec_in.a;
            dec_out_ff.b <= embed_on ? dec_mark[1] : dec_in.b;
         end
      end
   end

   assign dec_out_valid = dec_out_valid_ff;
   assign dec_out       = dec_out_ff;

   a_mag_saturate: assert property (@(posedge clk) disable iff (srst)
      (lane_smp[0] == 12'h800) |-> (lane_mag[0] == 11'h7FF))
      else $error("most negative code not saturated");

   a_mag_example: assert property (@(posedge clk) disable iff (srst)
      (lane_smp[1] == 12'h810) |-> (lane_mag[1][10:3] == 8'hFE))
      else $error("magnitude of -2032 wrong");

   a_fg_halt: assert property (@(posedge clk) disable iff (srst)
      (smp_valid && cal_busy && !bg_cal) |=> !smp_out_valid)
      else $error("sample taken during foreground calibration");

   a_cfg_reset: assert property (@(posedge clk)
      ($past(srst) && !srst) |-> (ovr_cfg_ff == RST_OVR_CFG))
      else $error("config register reset value wrong");

   a_emb_i_lsb: assert property (@(posedge clk) disable iff (srst)
      (dec_valid && embed_cplx && !dec_phase) |=>
      (dec_out.a[0] == $past(emb_ff[0].high) && dec_out.a[15:1] == $past(dec_in.a[15:1])))
      else $error("I sample LSB not high-threshold status");

   a_emb_off: assert property (@(posedge clk) disable iff (srst)
      (dec_valid && !embed_on) |=> (dec_out == $past(dec_in)))
      else $error("data altered outside decimating formats");

   a_win_wrap: assert property (@(posedge clk) disable iff (srst)
      (take && embed_real && win_cnt_ff == WIN_W'(period - 9'h001)) |=> (win_cnt_ff == 9'h000))
      else $error("monitoring window did not wrap");

   a_pin_follow: assert property (@(posedge clk) disable iff (srst)
      (take && lane_hit[1].low) |=> chan_b_low_flag [*8])
      else $error("low flag pulse shorter than eight cycles");

   a_real_lsb: assert property (@(posedge clk) disable iff (srst)
      (dec_valid && embed_real && dec_phase) |=> (dec_out.b[0] == $past(emb_ff[1].low)))
      else $error("odd sample LSB not low-threshold status");

   a_win_cplx: assert property (@(posedge clk) disable iff (srst)
      (take && embed_cplx && win_cnt_ff == WIN_W'(period - 9'h001)) |=> (win_cnt_ff == 9'h000))
      else $error("complex monitoring window did not wrap");

   a_cfg_readback: assert property (@(posedge clk) disable iff (srst)
      (ap_take && !hwrite && addr_ok && haddr[11:2] == IDX_OVR_CFG) |=>
      (hrdata == {24'h000000, $past(ovr_cfg_ff)}))
      else $error("config register read back wrong");

   a_single_span: assert property (@(posedge clk) disable iff (srst)
      (take && single_mode && lane_hit[1].high) |=> chan_b_high_flag)
      else $error("second-edge sample missed its high pin");

endmodule // aord_top

/* verif/aord_rx_mon.sv */
// Downstream monitor that merges status pins and watches for a quiet low flag
`timescale 1ns/1ps
module aord_rx_mon #(
   parameter int IDLE_CYC = 64
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // Status pins
   input  wire logic single,
   input  wire logic a_high,
   input  wire logic a_low,
   input  wire logic b_high,
   input  wire logic b_low,
   // Decisions
   output logic      over_high,
   output logic      over_low,
   output logic      raise_gain
);
   int unsigned quiet_ff;
   // Single mode splits one input over both pin pairs
   assign over_high = a_high | (single & b_high);
   assign over_low  = a_low | (single & b_low);
   // Gain only creeps up after a long quiet spell, never on a short gap
   assign raise_gain = (quiet_ff >= IDLE_CYC);
   always_ff @(posedge clk) begin
      if (srst || over_low) begin
         quiet_ff <= 0;
      end else if (!raise_gain) begin
         quiet_ff <= quiet_ff + 1;
      end
   end
endmodule // aord_rx_mon

/* verif/tb.sv */
// Self-checking bench for the over-range detector
`timescale 1ns/1ps
module tb;
   import aord_pkg::*;
   logic           clk = 0, srst = 1, hsel = 0, hwrite = 0, hready;
   logic [31:0]    haddr = 0, hwdata = 0, hrdata, r;
   logic [1:0]     htrans = 0;
   logic [2:0]     hsize = 3'h2;
   logic           hreadyout, hresp, smp_valid = 0, cal_busy = 0, smp_out_valid;
   aord_lanes_type smp_in = '0, smp_out, es;
   logic           dec_valid = 0, dec_phase = 0, dec_out_valid;
   aord_dec_type   dec_in = '0, dec_out, dexp;
   logic [3:0]     fl;
   logic           chan_a_high_flag, chan_a_low_flag, chan_b_high_flag, chan_b_low_flag;
   logic           over_high, over_low, raise_gain, tk, h, ev = 0, run_chk = 0, dv = 0;
   logic [7:0]     m_high = 8'hE4, m_low = 8'h40;
   logic [2:0]     m_cfg = 3'h7;
   logic [12:0]    m_mode = 13'h0000;
   logic [31:0]    seed = 32'd57026;
   int             cnt[4], fails = 0, n_checks = 0, cyc = 0;

   always #20 clk = ~clk;
   assign hready = hreadyout;
   assign fl = {chan_b_low_flag, chan_b_high_flag, chan_a_low_flag, chan_a_high_flag};

   aord_top i_dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .smp_valid(smp_valid), .smp_in(smp_in),
      .cal_busy(cal_busy), .smp_out_valid(smp_out_valid), .smp_out(smp_out),
      .chan_a_high_flag(chan_a_high_flag), .chan_a_low_flag(chan_a_low_flag),
      .chan_b_high_flag(chan_b_high_flag), .chan_b_low_flag(chan_b_low_flag),
      .dec_valid(dec_valid), .dec_phase(dec_phase), .dec_in(dec_in),
      .dec_out_valid(dec_out_valid), .dec_out(dec_out));

   aord_rx_mon #(.IDLE_CYC(64)) i_mon (.clk(clk), .srst(srst), .single(m_mode[0]),
      .a_high(chan_a_high_flag), .a_low(chan_a_low_flag), .b_high(chan_b_high_flag),
      .b_low(chan_b_low_flag), .over_high(over_high), .over_low(over_low),
      .raise_gain(raise_gain));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic hit(input logic [11:0] c, input logic [7:0] t);
      logic [11:0] m;
      m = c[11] ? ((c == 12'h800) ? 12'h7FF : -c) : c;
      return m[10:3] >= t;
   endfunction

   function automatic logic emb_fmt(input logic [FMT_W-1:0] f);
      return f == FMT_REAL_DEC || (f >= FMT_CPLX_FIRST && f <= FMT_CPLX_LAST && f != FMT_CPLX_SKIP);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Master holds each phase until hready is seen high at an edge
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
      chk(hresp, 0);
   endtask

   function automatic logic [31:0] ba(input logic [IDX_W-1:0] i);
      return 32'({i, 2'b00});
   endfunction

   task automatic pulse(input aord_lanes_type s);
      @(posedge clk);
      smp_valid <= 1'b1;
      smp_in <= s;
      @(posedge clk);
      smp_valid <= 1'b0;
   endtask

   // Reference model of the stretched pins and the sample path
   always @(posedge clk) begin
      tk = smp_valid && !(cal_busy && !m_mode[MODE_BGCAL_BIT]);
      for (int k = 0; k < 4; k++) begin
         h = tk && hit(k < 2 ? smp_in.lane0 : smp_in.lane1, k[0] ? m_low : m_high);
         if (srst) cnt[k] = 0;
         else if (h) cnt[k] = 8 << m_cfg;
         else if (cnt[k] > 0) cnt[k]--;
      end
      ev = !srst && tk;
      dv = !srst && dec_valid;
      es = smp_in;
      cyc++;
      if (cyc > 30000) begin
         fails++;
         wrap_up();
      end
   end

   always @(negedge clk) begin
      if (run_chk) begin
         for (int k = 0; k < 4; k++) chk(fl[k], cnt[k] != 0);
         chk(smp_out_valid, ev);
         chk(dec_out_valid, dv);
         chk(hreadyout, 1);
         if (ev) chk(smp_out, es);
      end
   end

   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      run_chk = 1;
      ahb(0, ba(IDX_OVR_CFG), 0); chk(r, RST_OVR_CFG);
      ahb(0, ba(IDX_HIGH_THR), 0); chk(r, RST_HIGH_THR);
      ahb(0, ba(IDX_LOW_THR), 0); chk(r, RST_LOW_THR);
      ahb(0, ba(IDX_MODE), 0); chk(r, RST_MODE);
      ahb(0, 32'h0000_0900, 0); chk(r, 0);
      ahb(0, ba(IDX_OVR_CFG) + 1, 0); chk(r, 0);
      ahb(1, ba(IDX_OVR_CFG), 32'hFFFF_FFF8);
      ahb(0, ba(IDX_OVR_CFG), 0); chk(r, 0);
      // Every pulse length, with a retrigger partway through
      for (int n = 0; n < 8; n++) begin
         ahb(1, ba(IDX_OVR_CFG), n);
         m_cfg = n[2:0];
         pulse('{lane1: 12'h800, lane0: 12'h810});
         repeat (5) @(posedge clk);
         pulse('{lane1: 12'h000, lane0: 12'h7F0});
         repeat ((8 << n) + 4) @(posedge clk);
      end
      ahb(0, ba(IDX_STATUS), 0); chk(r, 0);
      pulse('{lane1: 12'h000, lane0: 12'h810});
      ahb(0, ba(IDX_STATUS), 0); chk(r, 32'h3);
      // Equal-to-threshold boundaries on both thresholds
      ahb(1, ba(IDX_HIGH_THR), 32'hFE); m_high = 8'hFE;
      ahb(1, ba(IDX_LOW_THR), 32'hFF); m_low = 8'hFF;
      ahb(1, ba(IDX_OVR_CFG), 0); m_cfg = 0;
      repeat (1100) @(posedge clk);
      pulse('{lane1: 12'h7F7, lane0: 12'h810});
      pulse('{lane1: 12'h7FF, lane0: 12'h80F});
      // Foreground calibration drops samples, background keeps them
      for (int m = 0; m < 2; m++) begin
         ahb(1, ba(IDX_MODE), m << 1); m_mode = 13'(m << 1);
         repeat (12) @(posedge clk);
         @(posedge clk);
         cal_busy <= 1'b1;
         smp_valid <= 1'b1;
         smp_in <= '{lane1: 12'h800, lane0: 12'h800};
         repeat (4) @(posedge clk);
         cal_busy <= 1'b0;
         smp_valid <= 1'b0;
      end
      // Single mode spreads a threshold over both pins
      ahb(1, ba(IDX_MODE), 1); m_mode = 13'h0001;
      repeat (12) @(posedge clk);
      pulse('{lane1: 12'h810, lane0: 12'h000});
      @(negedge clk);
      chk(over_high, 1);
      chk(chan_a_high_flag, 0);
      // Random samples and thresholds at hold length settings 0, 1 and 2
      for (int p = 0; p < 3; p++) begin
         m_high = 8'(xs());
         ahb(1, ba(IDX_HIGH_THR), 32'(m_high));
         ahb(0, ba(IDX_HIGH_THR), 0); chk(r, 32'(m_high));
         ahb(1, ba(IDX_LOW_THR), 32'(m_high >> 2)); m_low = m_high >> 2;
         ahb(1, ba(IDX_OVR_CFG), p); m_cfg = 3'(p);
         ahb(1, ba(IDX_MODE), 32'(p & 2)); m_mode = 13'(p & 2);
         repeat (600) begin
            @(posedge clk);
            r = xs();
            smp_valid <= r[0];
            cal_busy <= r[1] & r[2];
            smp_in <= r[31:8];
         end
         @(posedge clk);
         smp_valid <= 1'b0;
         cal_busy <= 1'b0;
      end
      // Embedded status in every decimating format, both phases
      ahb(1, ba(IDX_HIGH_THR), 32'hE4); m_high = 8'hE4;
      ahb(1, ba(IDX_LOW_THR), 32'h40); m_low = 8'h40;
      ahb(1, ba(IDX_OVR_CFG), 1); m_cfg = 3'h1;
      for (int f = 8; f < 18; f++) begin
         ahb(1, ba(IDX_MODE), f << MODE_FMT_LSB); m_mode = 13'(f << MODE_FMT_LSB);
         @(posedge clk);
         smp_valid <= 1'b1;
         smp_in <= '{lane1: 12'(xs()), lane0: 12'h400};
         repeat (12) @(posedge clk);
         for (int ph = 0; ph < 2; ph++) begin
            dec_valid <= 1'b1;
            dec_phase <= ph[0];
            dec_in <= xs();
            @(posedge clk);
            dexp = dec_in;
            if (emb_fmt(f[4:0])) begin
               dexp.a[0] = hit(smp_in.lane0, ph ? m_low : m_high);
               dexp.b[0] = hit(smp_in.lane1, ph ? m_low : m_high);
            end
            dec_valid <= 1'b0;
            @(negedge clk);
            chk(dec_out_valid, 1);
            chk(dec_out, dexp);
            @(posedge clk);
         end
         smp_valid <= 1'b0;
      end
      repeat (90) @(posedge clk);
      @(negedge clk);
      chk(raise_gain, 1);
      pulse('{lane1: 12'h000, lane0: 12'h400});
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(raise_gain, 0);
      wrap_up();
   end
endmodule // tb
